// [fsw_pkg.sv]
// Purpose: constants for the supply-pin fuse access decoder
// Assumes: supply level already classified into low/mid/high codes
// Notes: keys are counts of mid-level pulses between high-level pulses
package fsw_pkg;
  // supply level classes
  typedef enum logic [1:0] {
    FSW_LVL_LOW  = 2'b00,
    FSW_LVL_MID  = 2'b01,
    FSW_LVL_HIGH = 2'b10
  } fsw_level_t;
  // register identities after key decode
  typedef enum logic [2:0] {
    FSW_REG_NONE  = 3'b000,
    FSW_REG_TRIAL = 3'b001,
    FSW_REG_MAG   = 3'b010,
    FSW_REG_SIGN  = 3'b011,
    FSW_REG_OUTLK = 3'b100
  } fsw_reg_t;
  typedef enum logic [1:0] {
    FSW_MODE_TRIAL = 2'b00,
    FSW_MODE_BLOW  = 2'b01,
    FSW_MODE_READ  = 2'b10
  } fsw_mode_t;
  // key mid-pulse counts
  localparam logic [3:0] FSW_KEY_REG_MAG = 4'h0;
  localparam logic [3:0] FSW_KEY_REG_SIGN = 4'h1;
  localparam logic [3:0] FSW_KEY_REG_OUTLK = 4'h3;
  localparam logic [3:0] FSW_KEY_TRIAL_OUTCHK = 4'h3;
  localparam logic [3:0] FSW_KEY_MODE_BLOW = 4'hb;
  localparam logic [3:0] FSW_KEY_MODE_READ = 4'hc;
  // widths and reset values
  localparam int FSW_MAG_W = 8;
  localparam int FSW_OUTLK_W = 5;
  localparam int FSW_TRIAL_W = 4;
  localparam logic [7:0] FSW_MAG_RST = 8'h00;
  localparam logic [0:0] FSW_SIGN_RST = 1'h0;
  localparam logic [4:0] FSW_OUTLK_RST = 5'h00;
  // field positions
  localparam int FSW_SLOW_LSB = 0;
  localparam int FSW_SENSE_BIT = 2;
  localparam int FSW_LOCK_BIT = 4;
  localparam int FSW_CHK_BIT = 3;
  localparam logic [3:0] FSW_CODE_CHK_LOW = 4'h8;
  localparam logic [3:0] FSW_CODE_CHK_HIGH = 4'h9;
  localparam logic [1:0] FSW_SLOW_MIN = 2'h1;
  localparam logic [1:0] FSW_SLOW_MAX = 2'h3;
  // timing
  localparam int FSW_CLK_MHZ = 200;
  localparam int FSW_BLOW_NS = 100;
  localparam int FSW_BLOW_CYC = (FSW_BLOW_NS * FSW_CLK_MHZ + 999) / 1000;
endpackage

// [fsw_level_if.sv]
// Purpose: carries classified pulse events to the key decoder
// Assumes: one pulse per event
// Notes: none
`timescale 1ns/1ps
interface fsw_level_if;
  logic mid_fall;
  logic high_fall;
  logic high_rise;
  logic idle_low;
  modport src (output mid_fall, output high_fall, output high_rise, output idle_low);
  modport dst (input mid_fall, input high_fall, input high_rise, input idle_low);
endinterface

// [fsw_level_edge.sv]
// Purpose: turns supply level codes into edge events and a low-level flag
// Assumes: level code synchronous to mclk
// Notes: edge events are one-cycle pulses; idle_low is a level
`timescale 1ns/1ps
module fsw_level_edge (
  input wire logic mclk,
  input wire logic rst_b,
  input wire fsw_pkg::fsw_level_t supply_level,
  fsw_level_if.src ev
);
  import fsw_pkg::*;
  fsw_level_t prev_r;
  fsw_level_t prev_nxt;

  always_comb begin
    prev_nxt = supply_level;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= FSW_LVL_LOW;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // falling edges count as the event
  assign ev.mid_fall = (prev_r == FSW_LVL_MID) && (supply_level == FSW_LVL_LOW);
  assign ev.high_fall = (prev_r == FSW_LVL_HIGH) && (supply_level != FSW_LVL_HIGH);
  assign ev.high_rise = (prev_r != FSW_LVL_HIGH) && (supply_level == FSW_LVL_HIGH);
  assign ev.idle_low = (supply_level == FSW_LVL_LOW);

  a_mid_fall_cause: assert property (@(posedge mclk) disable iff (!rst_b)
    ev.mid_fall |-> $past(supply_level) == FSW_LVL_MID)
    else $error("mid fall without mid level");
endmodule

// [fsw_fuse_access.sv]
// Purpose: decodes supply-pin pulse keys to reach one-time fuse registers
// Assumes: levels pre-classified; fuse states come from sense amps
// Notes: blow strobe is a pulse to the fuse driver
`timescale 1ns/1ps
module fsw_fuse_access #(
  parameter int MAG_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire fsw_pkg::fsw_level_t supply_level,
  input wire logic blow_request,
  input wire logic [MAG_W-1:0] mag_fuse_blown,
  input wire logic sign_fuse_blown,
  input wire logic [4:0] outlk_fuse_blown,
  input wire logic fuse_marginal_low,
  input wire logic fuse_marginal_high,
  input wire logic magnet_detect,
  output logic switch_output_drive_low,
  output logic supply_current_raise,
  output logic blow_strobe,
  output logic [2:0] blow_reg,
  output logic [7:0] blow_bit,
  output logic [1:0] trial_slowdown,
  output logic [1:0] fuse_check_sel
);
  import fsw_pkg::*;

  // ----------------------------------------------------------------
  // level events
  // ----------------------------------------------------------------
  fsw_level_if ev ();
  fsw_level_edge u_edge (
    .mclk(mclk),
    .rst_b(rst_b),
    .supply_level(supply_level),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // key decode state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FSW_ST_IDLE  = 3'b000,
    FSW_ST_KEY1  = 3'b001,
    FSW_ST_KEY2  = 3'b010,
    FSW_ST_KEY3  = 3'b011,
    FSW_ST_TRIAL = 3'b100,
    FSW_ST_ACT   = 3'b101
  } fsw_state_t;

  fsw_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] k1_r, k1_nxt;
  logic [1:0] nhigh_r, nhigh_nxt;
  fsw_reg_t reg_r, reg_nxt;
  fsw_mode_t mode_r, mode_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [2:0] bitn_r, bitn_nxt;
  logic blow_r, blow_nxt;
  logic [7:0] blow_cnt_r, blow_cnt_nxt;

  logic locked;
  assign locked = outlk_fuse_blown[FSW_LOCK_BIT];

  // key as seen at the closing high pulse: first gap count, pulse count
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    k1_nxt = k1_r;
    nhigh_nxt = nhigh_r;
    reg_nxt = reg_r;
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    bitn_nxt = bitn_r;
    if (ev.mid_fall && cnt_r != 4'hf) begin
      cnt_nxt = cnt_r + 4'h1;
    end
    unique case (st_r)
      FSW_ST_IDLE: begin
        if (ev.high_fall) begin
          st_nxt = FSW_ST_KEY1;
          nhigh_nxt = 2'h1;
          cnt_nxt = 4'h0;
        end
      end
      FSW_ST_KEY1, FSW_ST_KEY2, FSW_ST_TRIAL: begin
        // in FSW_ST_KEY1 a high pulse with no mid pulses before it is a doubled high
        // a high pulse in trial closes the output/lock key
        if (ev.high_fall) begin
          if (cnt_r == 4'h0 && st_r == FSW_ST_KEY1) begin
            nhigh_nxt = 2'h2;
            k1_nxt = FSW_KEY_REG_MAG;
            st_nxt = FSW_ST_KEY2;
          end else if (st_r == FSW_ST_KEY1) begin
            k1_nxt = cnt_r;
            st_nxt = FSW_ST_KEY2;
            // trial register entered: first gap is register key
            if (nhigh_r == 2'h1 && cnt_r == FSW_KEY_TRIAL_OUTCHK) begin
              st_nxt = FSW_ST_TRIAL;
              reg_nxt = FSW_REG_TRIAL;
              mode_nxt = FSW_MODE_TRIAL;
              addr_nxt = 8'h01;
            end
          end else begin
            // second gap is the mode key
            st_nxt = FSW_ST_ACT;
            reg_nxt = FSW_REG_NONE;
            if (nhigh_r == 2'h2 && k1_r == FSW_KEY_REG_MAG) begin
              reg_nxt = FSW_REG_MAG;
            end else if (nhigh_r == 2'h1 && k1_r == FSW_KEY_REG_SIGN) begin
              reg_nxt = FSW_REG_SIGN;
            end else if (nhigh_r == 2'h1 && k1_r == FSW_KEY_REG_OUTLK) begin
              reg_nxt = FSW_REG_OUTLK;
            end
            mode_nxt = (cnt_r == FSW_KEY_MODE_READ) ? FSW_MODE_READ : FSW_MODE_BLOW;
            if (locked) begin
              reg_nxt = FSW_REG_NONE;
            end
            addr_nxt = 8'h01;
            bitn_nxt = 3'h0;
          end
          cnt_nxt = 4'h0;
        end else if (ev.mid_fall && st_r == FSW_ST_TRIAL) begin
          // mid pulses walk the trial code; fuse checks survive lock
          addr_nxt = addr_r + 8'h01;
        end
      end
      FSW_ST_KEY3: begin
        st_nxt = FSW_ST_IDLE;
      end
      FSW_ST_ACT: begin
        // address stops at the msb
        if (ev.mid_fall && reg_r != FSW_REG_NONE && !addr_r[7]) begin
          addr_nxt = {addr_r[6:0], 1'b0};
          bitn_nxt = bitn_r + 3'h1;
        end
      end
      default: begin
        st_nxt = FSW_ST_IDLE;
      end
    endcase
    // power-down while idle clears the register selection
    if (ev.idle_low && st_r == FSW_ST_IDLE) begin
      reg_nxt = FSW_REG_NONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= FSW_ST_IDLE;
      cnt_r <= 4'h0;
      k1_r <= 4'h0;
      nhigh_r <= 2'h0;
      reg_r <= FSW_REG_NONE;
      mode_r <= FSW_MODE_TRIAL;
      addr_r <= 8'h00;
      bitn_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      k1_r <= k1_nxt;
      nhigh_r <= nhigh_nxt;
      reg_r <= reg_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      bitn_r <= bitn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // trial register decode
  // ----------------------------------------------------------------
  logic trial_active;
  logic [3:0] tcode;
  logic sense_trial;
  logic sense_eff;
  assign trial_active = (st_r == FSW_ST_TRIAL);
  assign tcode = addr_r[3:0];
  assign sense_trial = trial_active && !locked && tcode[FSW_SENSE_BIT] && !tcode[FSW_CHK_BIT];
  // permanent sense fuse or trial sense bit
  assign sense_eff = outlk_fuse_blown[FSW_SENSE_BIT] | sense_trial;

  logic [1:0] slow_nxt, slow_r;
  logic [1:0] chk_nxt, chk_r;
  always_comb begin
    slow_nxt = outlk_fuse_blown[1:0];
    chk_nxt = 2'b00;
    if (trial_active && !locked && !tcode[FSW_CHK_BIT] && tcode[1:0] != 2'b00) begin
      slow_nxt = tcode[1:0];
    end
    if (trial_active && tcode == FSW_CODE_CHK_LOW) begin
      chk_nxt = 2'b01;
    end else if (trial_active && tcode == FSW_CODE_CHK_HIGH) begin
      chk_nxt = 2'b10;
    end
  end

  // ----------------------------------------------------------------
  // blow strobe and output
  // ----------------------------------------------------------------
  logic blow_ok;
  assign blow_ok = (st_r == FSW_ST_ACT) && (mode_r == FSW_MODE_BLOW) && (reg_r != FSW_REG_NONE) && !locked;

  always_comb begin
    blow_nxt = 1'b0;
    blow_cnt_nxt = blow_cnt_r;
    if (blow_cnt_r != 8'h00) begin
      blow_cnt_nxt = blow_cnt_r - 8'h01;
      blow_nxt = 1'b1;
    end else if (blow_request && blow_ok && !blow_r) begin
      blow_cnt_nxt = 8'(FSW_BLOW_CYC - 1);
      blow_nxt = 1'b1;
    end
  end

  logic read_bit;
  logic read_active;
  logic out_low_nxt, out_low_r;
  logic cur_nxt, cur_r;
  assign read_active = (st_r == FSW_ST_ACT) && (mode_r == FSW_MODE_READ) && (reg_r != FSW_REG_NONE);
  always_comb begin
    unique case (reg_r)
      FSW_REG_MAG: read_bit = mag_fuse_blown[bitn_r];
      FSW_REG_SIGN: read_bit = (bitn_r == 3'h0) ? sign_fuse_blown : 1'b0;
      FSW_REG_OUTLK: read_bit = (bitn_r <= 3'h4) ? outlk_fuse_blown[bitn_r] : 1'b0;
      default: read_bit = 1'b0;
    endcase
    if (read_active) begin
      out_low_nxt = read_bit;
    end else begin
      out_low_nxt = magnet_detect ^ sense_eff;
    end
    cur_nxt = (chk_r == 2'b01 && fuse_marginal_low) || (chk_r == 2'b10 && fuse_marginal_high);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slow_r <= 2'h0;
      chk_r <= 2'h0;
      blow_r <= 1'b0;
      blow_cnt_r <= 8'h00;
      out_low_r <= 1'b0;
      cur_r <= 1'b0;
    end else begin
      slow_r <= slow_nxt;
      chk_r <= chk_nxt;
      blow_r <= blow_nxt;
      blow_cnt_r <= blow_cnt_nxt;
      out_low_r <= out_low_nxt;
      cur_r <= cur_nxt;
    end
  end

  assign switch_output_drive_low = out_low_r;
  assign supply_current_raise = cur_r;
  assign blow_strobe = blow_r;
  assign blow_reg = reg_r;
  assign blow_bit = addr_r;
  assign trial_slowdown = slow_r;
  assign fuse_check_sel = chk_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_read_on;
    read_active;
  endsequence
  a_read_follows_fuse: assert property (@(posedge mclk) disable iff (!rst_b)
    s_read_on ##1 read_active |-> out_low_r == $past(read_bit))
    else $error("read output does not show fuse");
  a_lock_no_read: assert property (@(posedge mclk) disable iff (!rst_b)
    locked && $changed(st_r) && st_r == FSW_ST_ACT |-> reg_r == FSW_REG_NONE)
    else $error("access after lock");
  a_lock_no_blow: assert property (@(posedge mclk) disable iff (!rst_b)
    locked && blow_cnt_r == 8'h00 |=> !blow_r)
    else $error("blow strobe while locked");
  a_check_current: assert property (@(posedge mclk) disable iff (!rst_b)
    chk_r == 2'b01 && fuse_marginal_low |=> cur_r)
    else $error("marginal fuse not flagged");
  a_check_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    chk_r == 2'b00 |=> !cur_r)
    else $error("current raised without check");
  a_trial_entry_code: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r != FSW_ST_TRIAL ##1 st_r == FSW_ST_TRIAL |-> addr_r == 8'h01)
    else $error("trial entry not at code 1");
  a_addr_onehot: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == FSW_ST_ACT && reg_r != FSW_REG_NONE |-> $onehot(addr_r) && addr_r == (8'h01 << bitn_r))
    else $error("blow address not one bit");
  a_check_sel: assert property (@(posedge mclk) disable iff (!rst_b)
    trial_active && tcode == FSW_CODE_CHK_HIGH |=> chk_r == 2'b10)
    else $error("high check not selected");
  a_trial_sense: assert property (@(posedge mclk) disable iff (!rst_b)
    trial_active && !locked && tcode == 4'h4 && !read_active |=> out_low_r == !$past(magnet_detect))
    else $error("trial sense not applied");
endmodule

// [fsw_prog_model.sv]
// Purpose: programmer model driving supply-pin pulse keys
// Assumes: levels already classified; pull-up on the switch output
// Notes: supply and blow request changes land on the falling edge of mclk
`timescale 1ns/1ps
module fsw_prog_model (
  input wire logic mclk,
  input wire logic switch_output_drive_low,
  output fsw_pkg::fsw_level_t supply_level,
  output logic blow_request,
  output logic switch_output
);
  import fsw_pkg::*;
  localparam int HOLD_CYC = 8;
  // ------------------------------------------------
  // pull-up and pulse tasks
  // ------------------------------------------------
  // open-drain output, pull-up for the whole session
  assign switch_output = switch_output_drive_low ? 1'b0 : 1'b1;
  initial begin
    supply_level = FSW_LVL_LOW;
    blow_request = 1'b0;
  end
  task automatic pulse(input fsw_level_t lvl, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      supply_level = lvl;
      repeat (3) @(negedge mclk);
      supply_level = FSW_LVL_LOW;
      repeat (3) @(negedge mclk);
    end
  endtask
  // dbl: two high pulses instead of high, mids, high
  task automatic enter(input int first, input bit dbl, input int second);
    if (dbl) begin
      pulse(FSW_LVL_HIGH, 2);
    end else begin
      pulse(FSW_LVL_HIGH, 1);
      pulse(FSW_LVL_MID, first);
      pulse(FSW_LVL_HIGH, 1);
    end
    pulse(FSW_LVL_MID, second);
    pulse(FSW_LVL_HIGH, 1);
  endtask
  // only called in blow sessions, never in read
  task automatic blow();
    @(negedge mclk);
    blow_request = 1'b1;
    repeat (2) @(negedge mclk);
    blow_request = 1'b0;
    repeat (HOLD_CYC) @(negedge mclk);
  endtask
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the fuse access decoder
// Assumes: sessions end only on reset
// Notes: expected values from the package constants and from literal codes
`timescale 1ns/1ps
module tb_top;
  import fsw_pkg::*;
  logic mclk;
  logic rst_b;
  fsw_level_t supply_level;
  logic blow_request;
  logic [7:0] mag_fuse_blown;
  logic sign_fuse_blown;
  logic [4:0] outlk_fuse_blown;
  logic fuse_marginal_low;
  logic fuse_marginal_high;
  logic magnet_detect;
  logic switch_output_drive_low;
  logic switch_output;
  logic supply_current_raise;
  logic blow_strobe;
  logic [2:0] blow_reg;
  logic [7:0] blow_bit;
  logic [1:0] trial_slowdown;
  logic [1:0] fuse_check_sel;
  int fails;
  int comparisons;
  // ------------------------------------------------
  // clock, design and programmer
  // ------------------------------------------------
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  fsw_fuse_access #(.MAG_W(FSW_MAG_W)) DUT (
    .mclk(mclk), .rst_b(rst_b), .supply_level(supply_level), .blow_request(blow_request),
    .mag_fuse_blown(mag_fuse_blown), .sign_fuse_blown(sign_fuse_blown),
    .outlk_fuse_blown(outlk_fuse_blown), .fuse_marginal_low(fuse_marginal_low),
    .fuse_marginal_high(fuse_marginal_high), .magnet_detect(magnet_detect),
    .switch_output_drive_low(switch_output_drive_low), .supply_current_raise(supply_current_raise),
    .blow_strobe(blow_strobe), .blow_reg(blow_reg), .blow_bit(blow_bit),
    .trial_slowdown(trial_slowdown), .fuse_check_sel(fuse_check_sel)
  );
  fsw_prog_model prog (
    .mclk(mclk), .switch_output_drive_low(switch_output_drive_low), .supply_level(supply_level),
    .blow_request(blow_request), .switch_output(switch_output)
  );
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_reset();
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  // blow pulse while counting strobe cycles
  task automatic blow_count(input logic [7:0] exp);
    int n;
    n = 0;
    fork
      prog.blow();
      repeat (40) begin
        @(negedge mclk);
        if (blow_strobe === 1'b1) n++;
      end
    join
    chk("strobe_cycles", exp, 8'(n));
  endtask
  task automatic summarize();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    summarize();
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    rst_b = 1'b0;
    mag_fuse_blown = 8'h00;
    sign_fuse_blown = 1'b0;
    outlk_fuse_blown = 5'h00;
    fuse_marginal_low = 1'b0;
    fuse_marginal_high = 1'b0;
    magnet_detect = 1'b0;
    fails = 0;
    comparisons = 0;
    do_reset();
    chk("blow_reg_rst", 8'h00, 8'(blow_reg));
    // trial output / fuse check register
    prog.pulse(FSW_LVL_HIGH, 1);
    prog.pulse(FSW_LVL_MID, 3);
    prog.pulse(FSW_LVL_HIGH, 1);
    chk("blow_reg_trial", 8'(FSW_REG_TRIAL), 8'(blow_reg));
    chk("trial_code", 8'h01, blow_bit);
    chk("slow_min", 8'(FSW_SLOW_MIN), 8'(trial_slowdown));
    prog.pulse(FSW_LVL_MID, 2);
    chk("slow_max", 8'(FSW_SLOW_MAX), 8'(trial_slowdown));
    prog.pulse(FSW_LVL_MID, 1);
    chk("trial_sense", 8'h00, 8'(switch_output));
    prog.pulse(FSW_LVL_MID, 4);
    chk("check_low", 8'h01, 8'(fuse_check_sel));
    fuse_marginal_low = 1'b1;
    repeat (3) @(negedge mclk);
    chk("raise_low", 8'h01, 8'(supply_current_raise));
    prog.pulse(FSW_LVL_MID, 1);
    chk("check_high", 8'h02, 8'(fuse_check_sel));
    chk("raise_clean", 8'h00, 8'(supply_current_raise));
    fuse_marginal_high = 1'b1;
    repeat (3) @(negedge mclk);
    chk("raise_high", 8'h01, 8'(supply_current_raise));
    fuse_marginal_low = 1'b0;
    fuse_marginal_high = 1'b0;
    // read back magnitude, sense blown must not invert
    do_reset();
    mag_fuse_blown = 8'h59;
    outlk_fuse_blown = 5'h04;
    magnet_detect = 1'b1;
    prog.enter(0, 1'b1, 12);
    chk("blow_reg_read", 8'(FSW_REG_MAG), 8'(blow_reg));
    for (int i = 0; i < 8; i++) begin
      if (i > 0) prog.pulse(FSW_LVL_MID, 1);
      chk("read_bit", 8'(!mag_fuse_blown[i]), 8'(switch_output));
    end
    // blow the field sign
    do_reset();
    outlk_fuse_blown = 5'h00;
    prog.enter(1, 1'b0, 11);
    chk("blow_reg_sign", 8'(FSW_REG_SIGN), 8'(blow_reg));
    chk("sign_addr", 8'h01, blow_bit);
    blow_count(8'(FSW_BLOW_CYC));
    // magnitude addressing, bit 1 already blown
    do_reset();
    mag_fuse_blown = 8'h02;
    prog.enter(0, 1'b1, 11);
    chk("blow_reg_mag", 8'(FSW_REG_MAG), 8'(blow_reg));
    for (int i = 0; i < 8; i++) begin
      if (i > 0) prog.pulse(FSW_LVL_MID, 1);
      chk("mag_addr", 8'h01 << i, blow_bit);
    end
    blow_count(8'(FSW_BLOW_CYC));
    // output / lock register, lock bit address
    do_reset();
    prog.enter(3, 1'b0, 11);
    chk("blow_reg_outlk", 8'(FSW_REG_OUTLK), 8'(blow_reg));
    prog.pulse(FSW_LVL_MID, 4);
    chk("lock_addr", 8'h10, blow_bit);
    // locked device
    do_reset();
    outlk_fuse_blown = 5'h10;
    prog.enter(0, 1'b1, 12);
    chk("read_refused", 8'h00, 8'(blow_reg));
    do_reset();
    prog.enter(0, 1'b1, 11);
    chk("blow_refused", 8'h00, 8'(blow_reg));
    blow_count(8'h00);
    do_reset();
    prog.pulse(FSW_LVL_HIGH, 1);
    prog.pulse(FSW_LVL_MID, 3);
    prog.pulse(FSW_LVL_HIGH, 1);
    chk("slow_locked", 8'h00, 8'(trial_slowdown));
    prog.pulse(FSW_LVL_MID, 7);
    chk("check_locked", 8'h01, 8'(fuse_check_sel));
    summarize();
  end
endmodule
